// ---- rtl/lpc_pkg.sv ----
package lpc_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] ADDR_DIV_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STOP_A = 4'h1;
    localparam logic [3:0] ADDR_STOP_B = 4'h2;
    localparam logic [3:0] ADDR_STOP_C = 4'h3;
    localparam logic [3:0] ADDR_PWR_MODE = 4'h4;
    localparam logic [3:0] ADDR_STBY_CTRL = 4'h5;
    localparam logic [3:0] ADDR_RUN_CTRL = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;

    // Reset values
    localparam logic [31:0] STOP_A_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] STOP_B_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] STOP_C_RST = 32'hFFFF_FFFF;
    localparam logic [15:0] DIV_RST = 16'h0000;
    localparam logic [31:0] RUN_RST = 32'h0000_0000;

    // Module stop bit positions
    localparam int STOP_TIMER8_UNIT1 = 4;
    localparam int STOP_TIMER8_UNIT0 = 5;
    localparam int STOP_DAC = 19;
    localparam int STOP_CAN = 0;
    localparam int STOP_EVENT_LINK = 9;
    localparam int STOP_COMPARATOR_B = 10;
    localparam int STOP_USB = 19;
    localparam int STOP_SERIAL6 = 25;
    localparam int STOP_SERIAL9 = 26;
    localparam int STOP_SERIAL8 = 27;

    // Divider field positions, four bits each
    localparam int DIV_SYS_POS = 0;
    localparam int DIV_PERIPH_POS = 4;
    localparam int DIV_CONV_POS = 8;
    localparam int DIV_FLASH_POS = 12;

    // Standby control field positions
    localparam int STBY_SW_POS = 0;
    localparam int STBY_DEEP_POS = 1;
    localparam int STBY_SNZ_EN_POS = 2;

    // Operating power control modes
    localparam logic [2:0] PWR_HIGH = 3'h0;
    localparam logic [2:0] PWR_MID = 3'h2;
    localparam logic [2:0] PWR_MID2 = 3'h4;
    localparam logic [2:0] PWR_LOW = 3'h6;
    localparam int PWR_LOW_POS = 7;

    // Run-control bits of register-controlled units
    localparam int RUN_MAIN_OSC = 0;
    localparam int RUN_SUB_OSC = 1;
    localparam int RUN_FAST_OSC = 2;
    localparam int RUN_SLOW_OSC = 3;
    localparam int RUN_WDT_OSC = 4;
    localparam int RUN_PLL = 5;
    localparam int RUN_WDT = 6;
    localparam int RUN_RTC = 7;
    localparam int RUN_LPT = 8;
    localparam int RUN_VDET = 9;
    localparam int RUN_RTC_OUT = 10;
    localparam int RUN_CLK_OUT = 11;
    localparam int RUN_WIDTH = 12;

    // Power states
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SLEEP = 3'b001,
        ST_DEEP = 3'b010,
        ST_SSTBY = 3'b011,
        ST_SNOOZE = 3'b100
    } pwr_state_t;

    // Freeze controls for retained units
    typedef struct packed {
        logic cpu;
        logic transfer_controller;
        logic flash;
        logic ram;
        logic periph;
        logic io_hold;
    } freeze_t;

    // Clock divider selects
    typedef struct packed {
        logic [3:0] flash;
        logic [3:0] conv;
        logic [3:0] periph;
        logic [3:0] sys;
    } clk_div_t;

endpackage

// ---- rtl/low_power_mode_controller.sv ----
// Contract
// - Four clock dividers programmed independently
// - One stop bit per peripheral module
// - Sleep, deep sleep, standby, snooze states
// - Enter standby states by register plus wait
// - Standby states return to run only on interrupt
// - Wake resumes CPU via waking interrupt
// - Snooze from standby; exits interrupt or end
// - Frozen units retain registers, suspend operation
// - Optional units follow their own register; main oscillator and PLL forced off in software standby
// - Work RAM retained; usable sleep and snooze
// - Power mode selectable in run, sleep, deep, snooze
// - Mode codes 000, 010, 100; others prohibited
// - Stop A: bits 4, 5, 19
// - Stop B: bits 0, 9, 10, 19, 25
// - Stop C: bits 26 and 27
// - Four power modes chosen by register
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_controller
    import lpc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // CPU and wake sources
    input wire logic cpu_wait_i,
    input wire logic irq_i,
    input wire logic snooze_req_i,
    input wire logic snooze_end_i,
    // Clock and power controls
    output clk_div_t clk_div_o,
    output logic [2:0] power_mode_sel_o,
    output logic [31:0] stop_a_o,
    output logic [31:0] stop_b_o,
    output logic [31:0] stop_c_o,
    output logic [RUN_WIDTH-1:0] unit_run_o,
    output freeze_t freeze_o,
    output logic wake_irq_o,
    output pwr_state_t state_o
);

    // Software-visible registers
    logic [15:0] div_q;
    logic [31:0] stop_a_q;
    logic [31:0] stop_b_q;
    logic [31:0] stop_c_q;
    logic [2:0] pwr_mode_q;
    logic [2:0] stby_q;
    logic [RUN_WIDTH-1:0] run_q;
    logic bad_mode_q;
    // State machine
    pwr_state_t state_q;
    pwr_state_t state_d;
    // Outputs registered
    logic [31:0] rdata_q;
    logic [RUN_WIDTH-1:0] unit_run_q;
    freeze_t freeze_q;
    freeze_t freeze_d;
    logic [RUN_WIDTH-1:0] run_d;
    logic wake_q;

    // Divider register, each field independent
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // Dividers start at their reset ratio
            div_q <= DIV_RST;
        end
        else if (reg_wr_i && reg_addr_i == ADDR_DIV_CTRL)
        begin
            // One write loads all four fields; no field feeds another
            div_q <= reg_wdata_i[15:0];
        end
    end

    // Module stop registers, one bit per module
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // Every module starts stopped until software enables it
            stop_a_q <= STOP_A_RST;
            stop_b_q <= STOP_B_RST;
            stop_c_q <= STOP_C_RST;
        end
        else if (reg_wr_i)
        begin
            // Every bit stored alone; timer, DAC bits live in A
            if (reg_addr_i == ADDR_STOP_A)
            begin
                stop_a_q <= reg_wdata_i;
            end
            // CAN, event link, comparator, USB, serial 6 in B
            if (reg_addr_i == ADDR_STOP_B)
            begin
                stop_b_q <= reg_wdata_i;
            end
            // Serial 8 and 9 in C
            if (reg_addr_i == ADDR_STOP_C)
            begin
                stop_c_q <= reg_wdata_i;
            end
        end
    end

    // Power mode select; prohibited codes are refused and flagged
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // High speed after reset, no refused write seen
            pwr_mode_q <= PWR_HIGH;
            bad_mode_q <= 1'b0;
        end
        else if (reg_wr_i && reg_addr_i == ADDR_PWR_MODE)
        begin
            // Writes accepted in every state; in standby the CPU cannot write anyway
            if (reg_wdata_i[PWR_LOW_POS])
            begin
                // Low speed sits behind its own select bit and wins over the code
                pwr_mode_q <= PWR_LOW;
                bad_mode_q <= 1'b0;
            end
            else if (reg_wdata_i[2:0] == PWR_HIGH || reg_wdata_i[2:0] == PWR_MID
                || reg_wdata_i[2:0] == PWR_MID2)
            begin
                // Legal three-bit codes load as written
                pwr_mode_q <= reg_wdata_i[2:0];
                bad_mode_q <= 1'b0;
            end
            else
            begin
                // Prohibited code: old mode kept, refusal flagged
                bad_mode_q <= 1'b1;
            end
        end
    end

    // Standby control and run-control registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // Standby choice clears to plain sleep
            stby_q <= 3'h0;
            run_q <= RUN_RST[RUN_WIDTH-1:0];
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == ADDR_STBY_CTRL)
            begin
                // Bit 0 software standby, bit 1 deep sleep, bit 2 snooze enable
                stby_q <= reg_wdata_i[2:0];
            end
            if (reg_addr_i == ADDR_RUN_CTRL)
            begin
                // Units that stay register-controlled in low power states
                run_q <= reg_wdata_i[RUN_WIDTH-1:0];
            end
        end
    end

    // Next power state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN:
            begin
                // Register picks the state, wait instruction commits
                if (cpu_wait_i)
                begin
                    if (stby_q[STBY_SW_POS])
                    begin
                        // Software standby has priority
                        state_d = ST_SSTBY;
                    end
                    else if (stby_q[STBY_DEEP_POS])
                    begin
                        // Deep sleep next
                        state_d = ST_DEEP;
                    end
                    else
                    begin
                        // Plain sleep otherwise
                        state_d = ST_SLEEP;
                    end
                end
            end
            ST_SLEEP, ST_DEEP:
            begin
                // Only an interrupt leaves
                if (irq_i)
                begin
                    state_d = ST_RUN;
                end
            end
            ST_SSTBY:
            begin
                // Interrupt wins over a snooze request
                if (irq_i)
                begin
                    state_d = ST_RUN;
                end
                // Snooze needs the request and its enable bit
                else if (snooze_req_i && stby_q[STBY_SNZ_EN_POS])
                begin
                    state_d = ST_SNOOZE;
                end
            end
            ST_SNOOZE:
            begin
                if (irq_i)
                begin
                    // Interrupt goes to program execution
                    state_d = ST_RUN;
                end
                else if (snooze_end_i)
                begin
                    // End condition drops back to software standby
                    state_d = ST_SSTBY;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // Program execution after reset
            state_q <= ST_RUN;
        end
        else
        begin
            // One transition per clock edge
            state_q <= state_d;
        end
    end

    // Wake pulse tells the CPU to take the waking interrupt
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // No wake pending after reset
            wake_q <= 1'b0;
        end
        else
        begin
            // High for one cycle as the state first reads run
            wake_q <= (state_q != ST_RUN) && (state_d == ST_RUN);
        end
    end

    // Freeze and run decode from the next state
    always_comb
    begin
        freeze_d = '0;
        run_d = run_q;
        unique case (state_d)
            ST_RUN:
            begin
                // Nothing frozen while the program runs
                freeze_d = '0;
            end
            ST_SLEEP:
            begin
                // CPU halted, RAM, TRANSFER_CONTROLLER, flash stay usable
                freeze_d.cpu = 1'b1;
            end
            ST_DEEP:
            begin
                // CPU, TRANSFER_CONTROLLER, flash and RAM held with contents kept
                freeze_d.cpu = 1'b1;
                freeze_d.transfer_controller = 1'b1;
                freeze_d.flash = 1'b1;
                freeze_d.ram = 1'b1;
            end
            ST_SSTBY:
            begin
                // All but the register-controlled units frozen
                freeze_d.cpu = 1'b1;
                freeze_d.transfer_controller = 1'b1;
                freeze_d.flash = 1'b1;
                freeze_d.ram = 1'b1;
                freeze_d.periph = 1'b1;
                freeze_d.io_hold = 1'b1;
                // Main oscillator and PLL off whatever run control says
                run_d[RUN_MAIN_OSC] = 1'b0;
                run_d[RUN_PLL] = 1'b0;
            end
            ST_SNOOZE:
            begin
                // RAM, TRANSFER_CONTROLLER and peripherals may run again
                freeze_d.cpu = 1'b1;
                freeze_d.flash = 1'b1;
            end
        endcase
    end

    // Registered control outputs
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // Nothing frozen and no unit enabled during reset
            freeze_q <= '0;
            unit_run_q <= RUN_RST[RUN_WIDTH-1:0];
        end
        else
        begin
            // Controls line up with the state register
            freeze_q <= freeze_d;
            unit_run_q <= run_d;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // Read data idle at zero
            rdata_q <= 32'h0000_0000;
        end
        else if (reg_rd_i)
        begin
            // Narrow registers sit in the low bits
            unique case (reg_addr_i)
                ADDR_DIV_CTRL: rdata_q <= {16'h0000, div_q};
                ADDR_STOP_A: rdata_q <= stop_a_q;
                ADDR_STOP_B: rdata_q <= stop_b_q;
                ADDR_STOP_C: rdata_q <= stop_c_q;
                ADDR_PWR_MODE: rdata_q <= {29'h0000_0000, pwr_mode_q};
                ADDR_STBY_CTRL: rdata_q <= {29'h0000_0000, stby_q};
                ADDR_RUN_CTRL: rdata_q <= {20'h0_0000, run_q};
                ADDR_STATUS: rdata_q <= {28'h000_0000, bad_mode_q, state_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
        else
        begin
            // Data stand for one cycle only
            rdata_q <= 32'h0000_0000;
        end
    end

    // Output assignments from flip-flops
    assign reg_rdata_o = rdata_q;
    assign clk_div_o = div_q;
    assign power_mode_sel_o = pwr_mode_q;
    assign stop_a_o = stop_a_q;
    assign stop_b_o = stop_b_q;
    assign stop_c_o = stop_c_q;
    assign unit_run_o = unit_run_q;
    assign freeze_o = freeze_q;
    assign wake_irq_o = wake_q;
    assign state_o = state_q;

endmodule // low_power_mode_controller

`default_nettype wire

// ---- verification/low_power_mode_controller_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpc_monitor
    import lpc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Wake and wait lines
    input wire logic cpu_wait_i,
    input wire logic irq_i,
    input wire logic snooze_req_i,
    input wire logic snooze_end_i,
    // Power outputs
    input wire logic [RUN_WIDTH-1:0] unit_run_o,
    input wire freeze_t freeze_o,
    input wire logic wake_irq_o,
    input wire pwr_state_t state_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_run_hold: assert property (
        state_o == ST_RUN && !cpu_wait_i |=> state_o == ST_RUN)
        else $error("run left without wait");
    a_irq_exit: assert property (
        state_o != ST_RUN && irq_i |=> state_o == ST_RUN)
        else $error("no exit on interrupt");
    a_sleep_stay: assert property (
        state_o inside {ST_SLEEP, ST_DEEP} && !irq_i |=> $stable(state_o))
        else $error("sleep left without interrupt");
    a_wake_pulse: assert property (
        state_o != ST_RUN ##1 state_o == ST_RUN |-> wake_irq_o ##1 !wake_irq_o)
        else $error("wake pulse wrong");
    a_snooze_entry: assert property (
        state_o != ST_SNOOZE ##1 state_o == ST_SNOOZE
        |-> $past(state_o) == ST_SSTBY && $past(snooze_req_i))
        else $error("snooze entered wrongly");
    a_snooze_end: assert property (
        state_o == ST_SNOOZE && !irq_i && snooze_end_i |=> state_o == ST_SSTBY)
        else $error("snooze end ignored");
    a_standby_osc: assert property (
        state_o == ST_SSTBY |-> !unit_run_o[RUN_MAIN_OSC] && !unit_run_o[RUN_PLL])
        else $error("oscillator runs in standby");
    a_deep_freeze: assert property (
        state_o == ST_DEEP |-> freeze_o.cpu && freeze_o.transfer_controller && freeze_o.flash)
        else $error("deep sleep not frozen");
    a_ram_usable: assert property (
        state_o inside {ST_SLEEP, ST_SNOOZE} |-> !freeze_o.ram && freeze_o.cpu)
        else $error("ram frozen while usable");

    // Main scenarios reached
    c_sleep: cover property (state_o == ST_SLEEP);
    c_snooze: cover property (state_o == ST_SNOOZE);
    c_wake: cover property (wake_irq_o);
endmodule // lpc_monitor

bind low_power_mode_controller lpc_monitor u_lpc_monitor (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .cpu_wait_i(cpu_wait_i), .irq_i(irq_i), .snooze_req_i(snooze_req_i),
    .snooze_end_i(snooze_end_i), .unit_run_o(unit_run_o), .freeze_o(freeze_o),
    .wake_irq_o(wake_irq_o), .state_o(state_o));
`default_nettype wire

// ---- verification/cpu_wake_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_wake_model (
    // Clock, reset and bench commands
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] cmd_i,
    input wire logic wake_irq_i,
    // Lines into the block
    output logic cpu_wait_o,
    output logic irq_o,
    output logic snooze_req_o,
    output logic snooze_end_o
);
    logic [1:0] dly_q; // Cycles left before the wait instruction
    // Snooze conditions follow the bench
    assign snooze_req_o = cmd_i[2];
    assign snooze_end_o = cmd_i[3];
    // Wait issued two cycles late; interrupt held until serviced
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dly_q <= 2'h0;
            cpu_wait_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            dly_q <= cmd_i[0] ? 2'h2 : dly_q - 2'(dly_q != 2'h0);
            cpu_wait_o <= (dly_q == 2'h1);
            irq_o <= cmd_i[1] | (irq_o & ~wake_irq_i);
        end
    end
endmodule // cpu_wake_model
`default_nettype wire

// ---- verification/low_power_mode_controller_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_tb;
    import lpc_pkg::*;
    logic ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, cpu_wait_i, irq_i, snooze_req_i, snooze_end_i;
    logic [3:0] reg_addr_i, cmd;
    logic [31:0] reg_wdata_i, reg_rdata_o, stop_a_o, stop_b_o, stop_c_o;
    clk_div_t clk_div_o;
    logic [2:0] power_mode_sel_o;
    logic [RUN_WIDTH-1:0] unit_run_o;
    freeze_t freeze_o;
    logic wake_irq_o;
    pwr_state_t state_o;
    int errors, cmp_count;
    // Stop bit table and low power state table
    logic [3:0] st_a [10] = '{ADDR_STOP_A, ADDR_STOP_A, ADDR_STOP_A, ADDR_STOP_B, ADDR_STOP_B,
        ADDR_STOP_B, ADDR_STOP_B, ADDR_STOP_B, ADDR_STOP_C, ADDR_STOP_C};
    int st_b [10] = '{STOP_TIMER8_UNIT1, STOP_TIMER8_UNIT0, STOP_DAC, STOP_CAN, STOP_EVENT_LINK,
        STOP_COMPARATOR_B, STOP_USB, STOP_SERIAL6, STOP_SERIAL9, STOP_SERIAL8};
    logic [1:0] lp_cfg [3] = '{2'h0, 2'h2, 2'h1};
    pwr_state_t lp_st [3] = '{ST_SLEEP, ST_DEEP, ST_SSTBY};
    logic [5:0] lp_frz [3] = '{6'h20, 6'h3C, 6'h3F};
    logic [11:0] lp_run [3] = '{12'hFFF, 12'hFFF, 12'hFDE};

    low_power_mode_controller u_low_power_mode_controller (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .cpu_wait_i(cpu_wait_i), .irq_i(irq_i), .snooze_req_i(snooze_req_i),
        .snooze_end_i(snooze_end_i), .clk_div_o(clk_div_o), .power_mode_sel_o(power_mode_sel_o),
        .stop_a_o(stop_a_o), .stop_b_o(stop_b_o), .stop_c_o(stop_c_o), .unit_run_o(unit_run_o),
        .freeze_o(freeze_o), .wake_irq_o(wake_irq_o), .state_o(state_o));
    cpu_wake_model u_cpu_wake_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
        .wake_irq_i(wake_irq_o), .cpu_wait_o(cpu_wait_i), .irq_o(irq_i),
        .snooze_req_o(snooze_req_i), .snooze_end_o(snooze_end_i));

    // Clock at 100 MHz
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // Compare and count
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task final_report;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One-cycle register write
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    // One-cycle read, data judged in the following cycle
    task rd(input logic [3:0] a, input logic [31:0] e, input string n);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(n, e, reg_rdata_o);
    endtask

    // One-cycle command to the partner
    task pulse(input logic [3:0] c);
        @(posedge ref_clk_i);
        cmd <= c;
        @(posedge ref_clk_i);
        cmd <= 4'h0;
    endtask

    // Bounded wait for a power state
    task wait_st(input pwr_state_t s);
        #1;
        for (int i = 0; i < 20 && state_o !== s; i++)
        begin
            @(posedge ref_clk_i);
            #1;
        end
        chk("state", 32'(s), 32'(state_o));
        if (state_o !== s)
            final_report;
    endtask

    // Interrupt wake and pulse check
    task wake;
        pulse(4'h2);
        wait_st(ST_RUN);
        chk("wake", 32'h0000_0001, 32'(wake_irq_o));
        chk("thaw", 32'h0000_0000, 32'(freeze_o));
        chk("kept", STOP_A_RST, stop_a_o);
        @(posedge ref_clk_i);
        #1;
        chk("wake_end", 32'h0000_0000, 32'(wake_irq_o));
    endtask

    task t_reset;
        rd(ADDR_STOP_A, STOP_A_RST, "stop_a");
        rd(ADDR_STOP_B, STOP_B_RST, "stop_b");
        rd(ADDR_STOP_C, STOP_C_RST, "stop_c");
        chk("run", RUN_RST, 32'(unit_run_o));
        chk("mode", 32'(PWR_HIGH), 32'(power_mode_sel_o));
        wr(4'h8, 32'hFFFF_FFFF);
        rd(4'h8, 32'h0000_0000, "unmapped");
    endtask

    task t_div;
        chk("div", 32'(DIV_RST), 32'(clk_div_o));
        wr(ADDR_DIV_CTRL, 32'h0000_4321);
        chk("div", 32'h0000_4321, 32'(clk_div_o));
        wr(ADDR_DIV_CTRL, 32'h0000_43A1);
        chk("div", 32'h0000_43A1, 32'(clk_div_o));
        rd(ADDR_DIV_CTRL, 32'h0000_43A1, "div_rb");
    endtask

    task t_stop;
        logic [31:0] m;
        for (int i = 0; i < 10; i++)
        begin
            m = ~(32'h0000_0001 << st_b[i]);
            wr(st_a[i], m);
            chk("stop_out", m, st_a[i] == ADDR_STOP_A ? stop_a_o : st_a[i] == ADDR_STOP_B ?
                stop_b_o : stop_c_o);
            // The two registers not written must still read all ones
            chk("stop_rest", 32'hFFFF_FFFF,
                (st_a[i] == ADDR_STOP_A ? 32'hFFFF_FFFF : stop_a_o) &
                (st_a[i] == ADDR_STOP_B ? 32'hFFFF_FFFF : stop_b_o) &
                (st_a[i] == ADDR_STOP_C ? 32'hFFFF_FFFF : stop_c_o));
            rd(st_a[i], m, "stop_rb");
            wr(st_a[i], 32'hFFFF_FFFF);
        end
    endtask

    task t_mode;
        logic [2:0] prev;
        logic bad;
        prev = PWR_HIGH;
        for (int c = 0; c < 8; c++)
        begin
            bad = !(c inside {0, 2, 4});
            wr(ADDR_PWR_MODE, 32'(c));
            if (!bad)
                prev = 3'(c);
            chk("mode", 32'(prev), 32'(power_mode_sel_o));
            rd(ADDR_STATUS, {28'h000_0000, bad, 3'h0}, "status");
        end
        wr(ADDR_PWR_MODE, 32'h0000_0080);
        chk("low_speed", 32'(PWR_LOW), 32'(power_mode_sel_o));
        rd(ADDR_PWR_MODE, 32'(PWR_LOW), "mode_rb");
        rd(ADDR_STATUS, 32'h0000_0000, "status_low");
    endtask

    task t_lp;
        wr(ADDR_RUN_CTRL, 32'h0000_0FFF);
        rd(ADDR_RUN_CTRL, 32'h0000_0FFF, "run_rb");
        wr(ADDR_PWR_MODE, 32'(PWR_MID));
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_STBY_CTRL, 32'(lp_cfg[i]));
            pulse(4'h1);
            wait_st(lp_st[i]);
            repeat (4) @(posedge ref_clk_i);
            #1;
            chk("hold", 32'(lp_st[i]), 32'(state_o));
            chk("freeze", 32'(lp_frz[i]), 32'(freeze_o));
            chk("unit_run", 32'(lp_run[i]), 32'(unit_run_o));
            if (i < 2)
            begin
                wr(ADDR_PWR_MODE, 32'(i ? PWR_MID : PWR_MID2));
                chk("mode_lp", 32'(i ? PWR_MID : PWR_MID2), 32'(power_mode_sel_o));
            end
            wake;
        end
    endtask

    task t_snooze;
        pulse(4'h4);
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk("snz_run", 32'(ST_RUN), 32'(state_o));
        wr(ADDR_STBY_CTRL, 32'h0000_0005);
        rd(ADDR_STBY_CTRL, 32'h0000_0005, "stby_rb");
        pulse(4'h1);
        wait_st(ST_SSTBY);
        repeat (2)
        begin
            pulse(4'h4);
            wait_st(ST_SNOOZE);
            chk("snz_freeze", 32'h0000_0028, 32'(freeze_o));
            // Power mode stays selectable while snoozing
            wr(ADDR_PWR_MODE, 32'(PWR_MID2));
            chk("mode_snz", 32'(PWR_MID2), 32'(power_mode_sel_o));
            pulse(4'h8);
            wait_st(ST_SSTBY);
        end
        pulse(4'h4);
        wait_st(ST_SNOOZE);
        wake;
    endtask

    // Main sequence
    initial
    begin
        rst_n_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 32'h0000_0000;
        cmd = 4'h0;
        errors = 0;
        cmp_count = 0;
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_div;
        t_stop;
        t_mode;
        t_lp;
        t_snooze;
        final_report;
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        final_report;
    end
endmodule // low_power_mode_controller_tb
`default_nettype wire
